// [core/conv_ctrl.sv]
// converter control: start, done flag, interrupt, channel, prescaler, standby, pseudo idle
`timescale 1ns/100ps
`include "conv_ctrl_map.svh"
//
// How it works
// - writing one to control bit 3 starts one conversion on selected channel
// - start bit clears itself when conversion finishes, serving as busy
// - done flag bit 4 sets with result held, stays until software clears
// - interrupt requested while done flag set and converter irq enable one
// - three-bit channel field selects analog input zero to seven binary
// - full scale 3FF at or above reference, 000 at or below ground
// - converter clock: prescale zero divides by 64, else by twice value
// - clearing enable bit puts converter in reduced-power standby
// - a conversion takes one sample period plus ten bit periods
// - precision conversion halts CPU until done; other interrupts deferred
// - start on channel not configured analog has no effect
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int DIVIDE_W = 5
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // special-function register access
    input  wire logic                 sfr_wr,
    input  wire logic [7:0]           sfr_addr,
    input  wire logic [7:0]           sfr_wdata,
    output logic      [7:0]           control_reg,
    output logic      [7:0]           result_high_reg,
    output logic      [7:0]           result_low_reg,
    output logic      [7:0]           pin_function_reg,
    output logic      [DIVIDE_W-1:0]  clock_divide_field,
    // interrupt side
    input  wire logic                 converter_irq_enable,
    input  wire logic                 other_irq_pending,
    output logic                      converter_irq,
    output logic                      cpu_halt,
    output logic                      hold_other_irq,
    // analog core side
    output logic      [2:0]           converter_input_sel,
    output logic                      converter_standby,
    output logic                      sample_hold,
    input  wire logic                 comparator_above,
    input  wire logic                 comparator_below
);
    import conv_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    chan_t          chan_ff;
    logic           start_busy_bit_ff;
    logic           conversion_done_flag_ff;
    logic           converter_enable_bit_ff;
    logic           pseudo_idle_bit_ff;
    logic [DIVIDE_W-1:0] divide_ff;
    logic [7:0]     pin_func_ff;
    result_t        result_ff;
    result_t        sar_ff;
    logic [3:0]     bit_cnt_ff;
    conv_state_e    state_ff;
    conv_state_e    nxt_state;
    logic           irq_ff;
    logic           halt_ff;
    logic           hold_ff;
    logic [2:0]     sel_ff;
    logic           stby_ff;
    logic           sh_ff;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire       ctrl_wr    = sfr_wr && (sfr_addr == `CTRL_REG_ADDR);
    wire       divide_wr  = sfr_wr && (sfr_addr == `PRESCALE_REG_ADDR);
    wire       pin_wr     = sfr_wr && (sfr_addr == `PIN_FUNC_ADDR);
    wire       wr_start   = ctrl_wr && sfr_wdata[`CTRL_START_BIT];
    wire       chan_ok    = pin_func_ff[chan_ff];
    wire       start_go   = start_busy_bit_ff && state_ff == ST_IDLE
                            && converter_enable_bit_ff && chan_ok;
    wire       tick;
    wire       finish     = (state_ff == ST_DONE);
    wire [3:0] bit_idx    = bit_cnt_ff - 4'h1;
    wire       conv_run   = (state_ff == ST_SAMPLE) || (state_ff == ST_BITS);
    // saturated, or successive trial per bit
    wire       trial      = !comparator_below;
    result_t   sar_trial;
    result_t   final_res;

    always_comb begin
        sar_trial          = sar_ff;
        sar_trial[bit_idx] = trial;
    end

    assign final_res = comparator_above ? `FULL_SCALE :
                       (comparator_below && sar_ff == '0) ? `ZERO_SCALE : sar_ff;

    conv_clk_div #(
        .DIV_W (DIVIDE_W)
    ) u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (conv_run),
        .divide  (divide_ff),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    always_comb begin
        case (state_ff)
            ST_IDLE:   nxt_state = start_go ? ST_SAMPLE : ST_IDLE;
            ST_SAMPLE: nxt_state = tick ? ST_BITS : ST_SAMPLE;
            ST_BITS:   nxt_state = (tick && bit_cnt_ff == 4'h1) ? ST_DONE : ST_BITS;
            ST_DONE:   nxt_state = ST_IDLE;
            default:   nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            sar_ff     <= '0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_SAMPLE && tick) begin
                bit_cnt_ff <= `CONV_PERIODS - 4'h1;
                sar_ff     <= '0;
            end else if (state_ff == ST_BITS && tick) begin
                bit_cnt_ff <= bit_cnt_ff - 4'h1;
                sar_ff     <= sar_trial;
            end
        end
    end

    // ----------------------------------------------------------------
    // control register and results
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chan_ff                 <= 3'h0;
            start_busy_bit_ff       <= 1'b0;
            conversion_done_flag_ff <= 1'b0;
            converter_enable_bit_ff <= 1'b0;
            pseudo_idle_bit_ff      <= 1'b0;
            divide_ff               <= `PRESCALE_RESET;
            pin_func_ff             <= `PIN_FUNC_RESET;
            result_ff               <= '0;
        end else begin
            if (ctrl_wr) begin
                chan_ff                 <= sfr_wdata[`CTRL_CH_LSB +: 3];
                converter_enable_bit_ff <= sfr_wdata[`CTRL_ENABLE_BIT];
                pseudo_idle_bit_ff      <= sfr_wdata[`CTRL_PSEUDO_IDLE_BIT];
                conversion_done_flag_ff <= sfr_wdata[`CTRL_DONE_BIT];
            end
            // start ignored when pin not analog or converter off
            if (wr_start && state_ff == ST_IDLE)
                start_busy_bit_ff <= 1'b1;
            else if (start_busy_bit_ff && state_ff == ST_IDLE && !start_go)
                start_busy_bit_ff <= 1'b0;
            if (finish) begin
                start_busy_bit_ff       <= 1'b0;
                conversion_done_flag_ff <= 1'b1;
                result_ff               <= final_res;
                pseudo_idle_bit_ff      <= 1'b0;
            end
            if (divide_wr)
                divide_ff <= sfr_wdata[DIVIDE_W-1:0];
            if (pin_wr)
                pin_func_ff <= sfr_wdata;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_ff  <= 1'b0;
            halt_ff <= 1'b0;
            hold_ff <= 1'b0;
            sel_ff  <= 3'h0;
            stby_ff <= 1'b1;
            sh_ff   <= 1'b0;
        end else begin
            irq_ff  <= conversion_done_flag_ff && converter_irq_enable;
            halt_ff <= pseudo_idle_bit_ff && start_busy_bit_ff && !finish;
            hold_ff <= pseudo_idle_bit_ff && start_busy_bit_ff && !finish
                       && other_irq_pending;
            sel_ff  <= chan_ff;
            stby_ff <= !converter_enable_bit_ff;
            sh_ff   <= (state_ff == ST_SAMPLE);
        end
    end

    assign control_reg         = {1'b0, pseudo_idle_bit_ff, converter_enable_bit_ff,
                                  conversion_done_flag_ff, start_busy_bit_ff, chan_ff};
    assign result_high_reg     = result_ff[9:2];
    assign result_low_reg      = {6'h00, result_ff[1:0]};
    assign pin_function_reg    = pin_func_ff;
    assign clock_divide_field  = divide_ff;
    assign converter_irq       = irq_ff;
    assign cpu_halt            = halt_ff;
    assign hold_other_irq      = hold_ff;
    assign converter_input_sel = sel_ff;
    assign converter_standby   = stby_ff;
    assign sample_hold         = sh_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_start_launch;
        @(posedge clk) disable iff (sys_rst)
        start_go |=> state_ff == ST_SAMPLE;
    endproperty
    a_start_launch: assert property (p_start_launch) else $error("start not launched");

    property p_busy_clear;
        @(posedge clk) disable iff (sys_rst)
        finish && !wr_start |=> !start_busy_bit_ff;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");

    property p_done_set;
        @(posedge clk) disable iff (sys_rst)
        finish |=> conversion_done_flag_ff;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        conversion_done_flag_ff && converter_irq_enable |=> converter_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_sel;
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> converter_input_sel == $past(chan_ff);
    endproperty
    a_sel: assert property (p_sel) else $error("channel not routed");

    property p_standby;
        @(posedge clk) disable iff (sys_rst)
        !converter_enable_bit_ff |=> converter_standby;
    endproperty
    a_standby: assert property (p_standby) else $error("standby missing");

    property p_ten_bits;
        @(posedge clk) disable iff (sys_rst)
        state_ff == ST_SAMPLE && tick |=> bit_cnt_ff == 4'hA;
    endproperty
    a_ten_bits: assert property (p_ten_bits) else $error("bit count wrong");

    property p_no_effect;
        @(posedge clk) disable iff (sys_rst)
        state_ff == ST_IDLE && start_busy_bit_ff && !chan_ok |=> state_ff == ST_IDLE;
    endproperty
    a_no_effect: assert property (p_no_effect) else $error("bad channel converted");

    property p_result_first;
        @(posedge clk) disable iff (sys_rst)
        $rose(conversion_done_flag_ff) && !$past(ctrl_wr) |-> $past(finish)
            && {result_high_reg, result_low_reg[1:0]} == $past(final_res);
    endproperty
    a_result_first: assert property (p_result_first) else $error("result late");
endmodule

// [core/conv_ctrl_map.svh]
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH

// special-function register addresses
`define CTRL_REG_ADDR     8'hF3
`define PRESCALE_REG_ADDR 8'hF2
`define RES_HIGH_ADDR     8'hF5
`define RES_LOW_ADDR      8'hF4
`define PIN_FUNC_ADDR     8'hF6

// control register fields
`define CTRL_CH_LSB       0
`define CTRL_START_BIT    3
`define CTRL_DONE_BIT     4
`define CTRL_ENABLE_BIT   5
`define CTRL_PSEUDO_IDLE_BIT 6
`define IRQ_EN_BIT        1

// reset values
`define CTRL_RESET        8'h00
`define PRESCALE_RESET    5'h00
`define PIN_FUNC_RESET    8'h00

// timing counts and result scale limits
`define ZERO_PRESCALE_DIV 7'h40
`define CONV_PERIODS      4'hB
`define FULL_SCALE        10'h3FF
`define ZERO_SCALE        10'h000

`endif

// [core/conv_ctrl_pkg.sv]
// types shared by the converter control files
package conv_ctrl_pkg;
    typedef logic [9:0] result_t;
    typedef logic [2:0] chan_t;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_BITS   = 2'b10,
        ST_DONE   = 2'b11
    } conv_state_e;
endpackage

// [core/conv_clk_div.sv]
// converter clock tick generator: divide by 64 for zero, else by twice the field
`timescale 1ns/100ps
`include "conv_ctrl_map.svh"
module conv_clk_div #(
    parameter int DIV_W = 5
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divide,
    output logic                  tick
);
    logic [6:0] cnt_ff;
    logic       tick_ff;
    wire  [6:0] period;
    wire        wrap;

    assign period = (divide == '0) ? `ZERO_PRESCALE_DIV : {1'b0, divide, 1'b0};
    assign wrap   = (cnt_ff >= period - 7'h01);
    assign tick   = tick_ff;

    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            cnt_ff  <= 7'h00;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= wrap ? 7'h00 : cnt_ff + 7'h01;
            tick_ff <= wrap;
        end
    end

    // tick spacing equals the selected period, checked only for divide one (two cycles)
    property p_tick_period;
        @(posedge clk) disable iff (sys_rst || !run)
        $rose(tick) && divide == 5'h01 && $stable(divide) |-> ##1 !tick ##1 tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
endmodule

// [bench/conv_analog_model.sv]
// analog core model: per-channel level at or above reference, or at or below ground
`timescale 1ns/100ps
module conv_analog_model (
    input  wire logic       converter_standby,
    input  wire logic [2:0] converter_input_sel,
    input  wire logic [7:0] high_mask,
    output logic            comparator_above,
    output logic            comparator_below
);
    // core in standby answers nothing
    assign comparator_above = !converter_standby && high_mask[converter_input_sel];
    assign comparator_below = !converter_standby && !high_mask[converter_input_sel];
endmodule

// [bench/adc_conversion_control_bench.sv]
// testbench of the converter control over all eight channels in order, with random levels and prescales
`timescale 1ns/100ps
`include "conv_ctrl_map.svh"
module adc_conversion_control_bench;
    logic       clk;
    logic       sys_rst;
    logic       sfr_wr;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] control_reg;
    logic [7:0] result_high_reg;
    logic [7:0] result_low_reg;
    logic [7:0] pin_function_reg;
    logic [4:0] clock_divide_field;
    logic       converter_irq_enable;
    logic       other_irq_pending;
    logic       converter_irq;
    logic       cpu_halt;
    logic       hold_other_irq;
    logic [2:0] converter_input_sel;
    logic       converter_standby;
    logic       sample_hold;
    logic       comparator_above;
    logic       comparator_below;
    logic [7:0] high_mask;
    int         err_count;
    int         comparisons;
    localparam int SETUP_CYCLES = 4;

    conv_ctrl #(.DIVIDE_W(5)) DUT (
        .clk(clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .control_reg(control_reg), .result_high_reg(result_high_reg),
        .result_low_reg(result_low_reg), .pin_function_reg(pin_function_reg),
        .clock_divide_field(clock_divide_field), .converter_irq_enable(converter_irq_enable),
        .other_irq_pending(other_irq_pending), .converter_irq(converter_irq),
        .cpu_halt(cpu_halt), .hold_other_irq(hold_other_irq),
        .converter_input_sel(converter_input_sel), .converter_standby(converter_standby),
        .sample_hold(sample_hold), .comparator_above(comparator_above),
        .comparator_below(comparator_below)
    );

    conv_analog_model analog (
        .converter_standby(converter_standby), .converter_input_sel(converter_input_sel),
        .high_mask(high_mask), .comparator_above(comparator_above),
        .comparator_below(comparator_below)
    );

    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    function automatic int div_of(input logic [4:0] p);
        return (p == 5'h00) ? 64 : 2 * int'(p);
    endfunction

    function automatic logic [15:0] exp_result(input logic hi);
        return hi ? 16'hFF03 : 16'h0000;
    endfunction

    task automatic wait_done(inout int n);
        while (control_reg[4] !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 2000) begin
                err_count++;
                complete_run();
            end
        end
    endtask

    // start without effect: nothing completes
    task automatic refuse(input logic [7:0] d);
        wr(`CTRL_REG_ADDR, d);
        repeat (40) @(negedge clk);
        check(control_reg[4], 1'b0);
        check(control_reg[3], 1'b0);
    endtask

    task automatic convert(input logic [2:0] ch, input logic prec, input logic [4:0] scale);
        int   n;
        int   d;
        logic hi;
        d = div_of(scale);
        hi = high_mask[ch];
        n = prec ? 4 : 2;
        if (prec) begin
            converter_irq_enable = 1'b1;
        end
        wr(`PRESCALE_REG_ADDR, {3'h0, scale});
        check(clock_divide_field, scale);
        wr(`CTRL_REG_ADDR, 8'h20 | {5'h00, ch});
        repeat (SETUP_CYCLES) @(negedge clk);
        check(converter_standby, 1'b0);
        wr(`CTRL_REG_ADDR, 8'h28 | {1'b0, prec, 6'h00} | {5'h00, ch});
        check(control_reg[3], 1'b1);
        check(converter_input_sel, ch);
        repeat (2) @(negedge clk);
        check(sample_hold, 1'b1);
        if (prec) begin
            check(cpu_halt, 1'b1);
            other_irq_pending = 1'b1;
            repeat (2) @(negedge clk);
            check(hold_other_irq, 1'b1);
        end
        wait_done(n);
        check((n + 2 >= 11 * d) && (n <= 12 * d + 3), 1'b1);
        check({result_high_reg, result_low_reg}, exp_result(hi));
        check(control_reg[3], 1'b0);
        @(negedge clk);
        check(converter_irq, converter_irq_enable);
        if (prec) begin
            @(negedge clk);
            check(cpu_halt, 1'b0);
            check(hold_other_irq, 1'b0);
            check(control_reg[6], 1'b0);
            other_irq_pending = 1'b0;
        end
        repeat (5) @(negedge clk);
        check(control_reg[4], 1'b1);
        wr(`CTRL_REG_ADDR, control_reg & 8'hEF);
        check(control_reg[4], 1'b0);
        @(negedge clk);
        check(converter_irq, 1'b0);
    endtask

    // ---------------------------------------------
    // clock and main sequence
    // ---------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        sys_rst = 1'b1;
        sfr_wr = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        converter_irq_enable = 1'b0;
        other_irq_pending = 1'b0;
        high_mask = 8'h00;
        err_count = 0;
        comparisons = 0;
        void'($urandom(32'hff63));
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        check(control_reg, 8'h00);
        check(converter_standby, 1'b1);
        check(converter_irq, 1'b0);
        wr(`PIN_FUNC_ADDR, 8'h0C);
        check(pin_function_reg, 8'h0C);
        wr(`PRESCALE_REG_ADDR, 8'h01);
        refuse(8'h0A);
        refuse(8'h28);
        converter_irq_enable = 1'b1;
        high_mask = 8'h04;
        convert(3'h2, 1'b0, 5'h00);
        wr(`PIN_FUNC_ADDR, 8'hFF);
        convert(3'h7, 1'b0, 5'h1F);
        for (int i = 0; i < 8; i++) begin
            high_mask = 8'($urandom);
            converter_irq_enable = 1'($urandom);
            convert(3'(i), 1'(i % 3 == 2), (i == 0) ? 5'h01 : 5'($urandom_range(1, 8)));
        end
        wr(`CTRL_REG_ADDR, 8'h00);
        @(negedge clk);
        check(converter_standby, 1'b1);
        complete_run();
    end
endmodule
